// ==== hw/eup_pkg.sv ====
// Constants, types and helpers for the extended serial data path.
// Assumes an APB register bus with 32-bit data and byte addresses.
package eup_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_DATA_LOW  = 8'h00;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h04;
  localparam logic [7:0] OFS_SIZE_CFG  = 8'h08;
  localparam logic [7:0] OFS_CTRL_B    = 8'h0C;
  localparam logic [7:0] OFS_STAT_A    = 8'h10;
  localparam logic [7:0] OFS_EXT_CTRL  = 8'h14;
  localparam logic [7:0] OFS_EXT_STAT  = 8'h18;
  localparam logic [7:0] OFS_LINE_CFG  = 8'h1C;

  // Reset values
  localparam logic [7:0]  SIZE_CFG_RST = 8'h33;
  localparam logic [15:0] DIV_RST      = 16'h0010;

  // Field positions
  localparam int SZ_TX_LSB  = 4;
  localparam int SZ_RX_LSB  = 0;
  localparam int CB_RX_EN   = 4;
  localparam int CB_TX_EN   = 3;
  localparam int CB_RX9     = 1;
  localparam int CB_TX9     = 0;
  localparam int SA_RXC     = 7;
  localparam int SA_TBE     = 5;
  localparam int SA_FE      = 4;
  localparam int SA_DOR     = 3;
  localparam int SA_UPE     = 2;
  localparam int EC_EXT     = 4;
  localparam int EC_RX2STOP = 3;
  localparam int EC_MANCH   = 1;
  localparam int EC_MSB     = 0;
  localparam int ES_FEM     = 3;
  localparam int ES_F1617   = 2;
  localparam int LC_PAR     = 16;
  localparam int LC_SYNC    = 18;
  localparam int LC_TX2STOP = 19;

  // Size code for automatic 16-or-17-bit reception
  localparam logic [3:0] SZ_AUTO = 4'hE;
  localparam logic [4:0] LEN_16  = 5'h10;
  localparam logic [4:0] LEN_17  = 5'h11;

  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} eup_tx_e;
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} eup_rx_e;

  // Character length from a size code
  function automatic logic [4:0] eup_len(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3,
      4'h8, 4'h9, 4'hA, 4'hB: eup_len = {1'b0, c} + 5'h05;
      4'h7:                   eup_len = 5'h09;
      4'hE, 4'hF:             eup_len = LEN_17;
      default:                eup_len = 5'h08;
    endcase
  endfunction

  // Mask of the low n bits of a character
  function automatic logic [16:0] eup_mask(input logic [4:0] n);
    eup_mask = 17'h1FFFF >> (LEN_17 - n);
  endfunction

endpackage

// ==== hw/eup_tick.sv ====
// Half-bit timing tick for one direction of the serial line.
// Assumes xck is synchronous to pclk; restart aligns to a start edge.
module eup_tick
  import eup_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        restart,
  input  wire logic        sync_mode,
  input  wire logic        external_serial_clock,
  input  wire logic [15:0] div,
  output logic             tick
);

  logic [15:0] cnt_r, cnt_nxt;
  logic        xck_r;
  logic        tick_nxt;
  logic [15:0] half;

  always_comb begin
    half     = {1'b0, div[15:1]};
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (sync_mode) begin
      tick_nxt = external_serial_clock ^ xck_r;
    end else if (restart) begin
      // Input and tick latency come off the quarter bit
      cnt_nxt = (div[15:2] > 14'h0003) ? {2'b00, div[15:2]} - 16'h0003 : 16'h0000;
    end else if (cnt_r == 16'h0000) begin
      tick_nxt = 1'b1;
      cnt_nxt  = (half > 16'h0001) ? half - 16'h0001 : 16'h0000;
    end else begin
      cnt_nxt = cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      xck_r <= 1'b0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      xck_r <= external_serial_clock;
      tick  <= tick_nxt;
    end
  end

endmodule

// ==== hw/eup_core.sv ====
// Extended serial port data path: APB registers, transmitter, receiver.
// Assumes pins are synchronous to pclk and software keeps its own order.
//
// Design decisions made here: register access over APB and the placing of the registers.
module eup_core
  import eup_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd_pin,
  input  wire logic        xck_pin,
  output logic             txd_pin,
  output logic             txd_pin_oe,
  output logic             rxd_owned
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus

  logic [7:0]  size_r, size_nxt;
  logic        rx_en_r, rx_en_nxt, tx_en_r, tx_en_nxt, tx9_r, tx9_nxt;
  logic        ext_r, ext_nxt, rx2s_r, rx2s_nxt, manch_r, manch_nxt;
  logic        msb_r, msb_nxt;
  logic [15:0] div_r, div_nxt;
  logic [1:0]  par_r, par_nxt;
  logic        sync_r, sync_nxt, tx2s_r, tx2s_nxt;
  logic [7:0]  thi_r, thi_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt, pslverr_nxt;
  logic        acc, wr, rd_low, wr_low, hit;

  // Receive buffer state, driven by the receive group; tbe_r is driven by the transmitter
  logic [7:0]  rlo_r, rhi_r;
  logic        rx9_r, rxc_r, fe_r, dor_r, upe_r, fem_r, f17_r, s1_r, s2_r;
  logic        tbe_r;

  always_comb begin
    acc         = psel & penable & ~pready;
    wr          = psel & penable & pready & pwrite;
    rd_low      = acc & ~pwrite & (paddr == OFS_DATA_LOW);
    wr_low      = wr & (paddr == OFS_DATA_LOW);
    size_nxt    = size_r;
    rx_en_nxt   = rx_en_r;
    tx_en_nxt   = tx_en_r;
    tx9_nxt     = tx9_r;
    ext_nxt     = ext_r;
    rx2s_nxt    = rx2s_r;
    manch_nxt   = manch_r;
    msb_nxt     = msb_r;
    div_nxt     = div_r;
    par_nxt     = par_r;
    sync_nxt    = sync_r;
    tx2s_nxt    = tx2s_r;
    thi_nxt     = thi_r;
    hit         = 1'b1;
    prdata_nxt  = 32'h0000_0000;
    case (paddr)
      OFS_DATA_LOW:  prdata_nxt[7:0] = rlo_r;
      OFS_DATA_HIGH: prdata_nxt[7:0] = rhi_r;
      OFS_SIZE_CFG:  prdata_nxt[7:0] = size_r;
      OFS_CTRL_B: begin
        prdata_nxt[CB_RX_EN] = rx_en_r;
        prdata_nxt[CB_TX_EN] = tx_en_r;
        prdata_nxt[CB_RX9]   = rx9_r;
        prdata_nxt[CB_TX9]   = tx9_r;
      end
      OFS_STAT_A: begin
        prdata_nxt[SA_RXC] = rxc_r;
        prdata_nxt[SA_TBE] = tbe_r;
        prdata_nxt[SA_FE]  = fe_r;
        prdata_nxt[SA_DOR] = dor_r;
        prdata_nxt[SA_UPE] = upe_r;
      end
      OFS_EXT_CTRL: begin
        prdata_nxt[EC_EXT]     = ext_r;
        prdata_nxt[EC_RX2STOP] = rx2s_r;
        prdata_nxt[EC_MANCH]   = manch_r;
        prdata_nxt[EC_MSB]     = msb_r;
      end
      OFS_EXT_STAT: prdata_nxt[7:0] = {4'h0, fem_r, f17_r, s2_r, s1_r};
      OFS_LINE_CFG: prdata_nxt = {12'h000, tx2s_r, sync_r, par_r, div_r};
      default:      hit = 1'b0;
    endcase
    if (wr) begin
      case (paddr)
        OFS_DATA_HIGH: thi_nxt = pwdata[7:0];
        OFS_SIZE_CFG:  size_nxt = pwdata[7:0];
        OFS_CTRL_B: begin
          rx_en_nxt = pwdata[CB_RX_EN];
          tx_en_nxt = pwdata[CB_TX_EN];
          tx9_nxt   = pwdata[CB_TX9];
        end
        OFS_EXT_CTRL: begin
          ext_nxt   = pwdata[EC_EXT];
          rx2s_nxt  = pwdata[EC_RX2STOP];
          manch_nxt = pwdata[EC_MANCH];
          msb_nxt   = pwdata[EC_MSB];
        end
        OFS_LINE_CFG: begin
          div_nxt  = pwdata[15:0];
          par_nxt  = pwdata[LC_PAR+1:LC_PAR];
          sync_nxt = pwdata[LC_SYNC];
          tx2s_nxt = pwdata[LC_TX2STOP];
        end
        default: ;
      endcase
    end
    pready_nxt  = acc;
    pslverr_nxt = acc & ~hit;
    if (!acc) prdata_nxt = prdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      size_r  <= SIZE_CFG_RST;
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
      tx9_r   <= 1'b0;
      ext_r   <= 1'b0;
      rx2s_r  <= 1'b0;
      manch_r <= 1'b0;
      msb_r   <= 1'b0;
      div_r   <= DIV_RST;
      par_r   <= 2'b00;
      sync_r  <= 1'b0;
      tx2s_r  <= 1'b0;
      thi_r   <= 8'h00;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      size_r  <= size_nxt;
      rx_en_r <= rx_en_nxt;
      tx_en_r <= tx_en_nxt;
      tx9_r   <= tx9_nxt;
      ext_r   <= ext_nxt;
      rx2s_r  <= rx2s_nxt;
      manch_r <= manch_nxt;
      msb_r   <= msb_nxt;
      div_r   <= div_nxt;
      par_r   <= par_nxt;
      sync_r  <= sync_nxt;
      tx2s_r  <= tx2s_nxt;
      thi_r   <= thi_nxt;
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter

  eup_tx_e     ts_r, ts_nxt;
  logic        ttick, tph_r, tph_nxt, ton_r, ton_nxt, tbe_nxt, txd_nxt;
  logic [4:0]  tcnt_r, tcnt_nxt, tn, tpos;
  logic [16:0] tbuf_r, tbuf_nxt, tsh_r, tsh_nxt;
  logic        tv, tpar, tman;

  eup_tick u_ttick (
    .pclk      (pclk),
    .presetn   (presetn),
    .restart   (1'b0),
    .sync_mode (sync_r),
    .external_serial_clock       (xck_pin),
    .div       (div_r),
    .tick      (ttick)
  );

  always_comb begin
    tn       = eup_len(size_r[SZ_TX_LSB+3:SZ_TX_LSB]);
    ts_nxt   = ts_r;
    tph_nxt  = tph_r;
    tcnt_nxt = tcnt_r;
    tsh_nxt  = tsh_r;
    tbuf_nxt = tbuf_r;
    tbe_nxt  = tbe_r;
    if (ttick) begin
      if (tph_r == 1'b0) begin
        tph_nxt = 1'b1;
      end else begin
        tph_nxt = 1'b0;
        case (ts_r)
          T_IDLE: begin
            tph_nxt = 1'b1;
            if (!tbe_r && ton_r) begin
              ts_nxt  = T_START;
              tph_nxt = 1'b0;
              tsh_nxt = tbuf_r;
              tbe_nxt = 1'b1;
            end
          end
          T_START: begin
            ts_nxt   = T_DATA;
            tcnt_nxt = 5'h00;
          end
          T_DATA: begin
            tcnt_nxt = tcnt_r + 5'h01;
            if (tcnt_r == tn - 5'h01) begin
              tcnt_nxt = 5'h00;
              ts_nxt   = (par_r[1] && !manch_r) ? T_PAR : T_STOP;
            end
          end
          T_PAR: ts_nxt = T_STOP;
          T_STOP: begin
            if (tx2s_r && tcnt_r == 5'h00) tcnt_nxt = 5'h01;
            else ts_nxt = T_IDLE;
          end
          default: ts_nxt = T_IDLE;
        endcase
      end
    end
    if (wr_low) begin
      tbuf_nxt = {tx9_r, thi_r, pwdata[7:0]};
      if (!ext_r) tbuf_nxt[8] = tx9_r;
      tbe_nxt = 1'b0;
    end
    tpos = msb_r ? (tn - 5'h01 - tcnt_nxt) : tcnt_nxt;
    tpar = ^(tsh_nxt & eup_mask(tn)) ^ par_r[0];
    tman = manch_r;
    case (ts_nxt)
      T_START: tv = tman;
      T_DATA:  tv = tsh_nxt[tpos];
      T_PAR:   tv = tpar;
      default: begin
        tv   = 1'b1;
        tman = 1'b0;
      end
    endcase
    txd_nxt = (tman && !tph_nxt) ? ~tv : tv;
    ton_nxt = tx_en_r | (ton_r & ((ts_r != T_IDLE) | !tbe_r));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_r       <= T_IDLE;
      tph_r      <= 1'b1;
      tcnt_r     <= 5'h00;
      tsh_r      <= 17'h00000;
      tbuf_r     <= 17'h00000;
      tbe_r      <= 1'b1;
      ton_r      <= 1'b0;
      txd_pin    <= 1'b1;
      txd_pin_oe <= 1'b0;
    end else begin
      ts_r       <= ts_nxt;
      tph_r      <= tph_nxt;
      tcnt_r     <= tcnt_nxt;
      tsh_r      <= tsh_nxt;
      tbuf_r     <= tbuf_nxt;
      tbe_r      <= tbe_nxt;
      ton_r      <= ton_nxt;
      txd_pin    <= txd_nxt;
      txd_pin_oe <= ton_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver

  eup_rx_e     rs_r, rs_nxt;
  logic        rtick, rrst, rph_r, rph_nxt, rha_r, rha_nxt, rpar_r, rpar_nxt;
  logic        rfe_r, rfe_nxt, rupe_r, rupe_nxt, rs1_r, rs1_nxt, rf17_r, rf17_nxt;
  logic [4:0]  rcnt_r, rcnt_nxt, rn, dn;
  logic [16:0] rsh_r, rsh_nxt, dd;
  logic        rauto, mer, done, dfem, b;
  logic [7:0]  rlo_nxt, rhi_nxt;
  logic        rx9_nxt, rxc_nxt, fe_nxt, dor_nxt, upe_nxt;
  logic        fem_nxt, f17_nxt, s1_nxt, s2_nxt;

  eup_tick u_rtick (
    .pclk      (pclk),
    .presetn   (presetn),
    .restart   (rrst),
    .sync_mode (sync_r),
    .external_serial_clock       (xck_pin),
    .div       (div_r),
    .tick      (rtick)
  );

  always_comb begin
    rn    = eup_len(size_r[SZ_RX_LSB+3:SZ_RX_LSB]);
    rauto = manch_r && (size_r[SZ_RX_LSB+3:SZ_RX_LSB] == SZ_AUTO);
    rrst  = (rs_r == R_IDLE) && rx_en_r && !rxd_pin && !sync_r;
    b     = rxd_pin;
    mer   = manch_r && (rha_r == b);
    rs_nxt = rs_r;
    rph_nxt = rph_r;
    rha_nxt = rha_r;
    rcnt_nxt = rcnt_r;
    rsh_nxt = rsh_r;
    rpar_nxt = rpar_r;
    rfe_nxt = rfe_r;
    rupe_nxt = rupe_r;
    rs1_nxt = rs1_r;
    rf17_nxt = rf17_r;
    done = 1'b0;
    dfem = 1'b0;
    dn   = rn;
    if (!rx_en_r) begin
      rs_nxt = R_IDLE;
    end else if (rs_r == R_IDLE) begin
      if (rrst || (sync_r && rtick && !b)) begin
        rs_nxt  = R_START;
        rph_nxt = sync_r;
        rha_nxt = b;
      end
    end else if (rtick) begin
      rph_nxt = ~rph_r;
      if (!rph_r) begin
        rha_nxt = b;
      end else begin
        case (rs_r)
          R_START: begin
            rcnt_nxt = 5'h00;
            rpar_nxt = 1'b0;
            rupe_nxt = 1'b0;
            rfe_nxt  = 1'b0;
            rf17_nxt = 1'b0;
            if (manch_r && (rha_r || !b)) begin
              dfem = 1'b1;
            end else if (!manch_r && b) begin
              rs_nxt = R_IDLE;
            end else begin
              rs_nxt = R_DATA;
            end
          end
          R_DATA: begin
            if (rauto && rcnt_r == LEN_16 && mer) begin
              done    = 1'b1;
              dn      = LEN_16;
              rs1_nxt = b;
            end else if (mer) begin
              dfem = 1'b1;
            end else begin
              rsh_nxt  = msb_r ? {rsh_r[15:0], b} : {b, rsh_r[16:1]};
              rpar_nxt = rpar_r ^ b;
              rcnt_nxt = rcnt_r + 5'h01;
              if (rcnt_r == rn - 5'h01) begin
                rf17_nxt = rauto;
                rcnt_nxt = 5'h00;
                rs_nxt   = (par_r[1] && !manch_r) ? R_PAR : R_STOP;
              end
            end
          end
          R_PAR: begin
            rupe_nxt = b ^ rpar_r ^ par_r[0];
            rs_nxt   = R_STOP;
          end
          R_STOP: begin
            if (rcnt_r == 5'h00) begin
              rs1_nxt = b;
              rfe_nxt = ~b;
              if (manch_r && rx2s_r) rcnt_nxt = 5'h01;
              else done = 1'b1;
            end else begin
              done = 1'b1;
            end
            dn = rf17_r ? LEN_17 : (rauto ? LEN_16 : rn);
          end
          default: rs_nxt = R_IDLE;
        endcase
      end
    end
    if (done || dfem) rs_nxt = R_IDLE;
    // Character alignment and buffer load
    dd = msb_r ? (rsh_nxt & eup_mask(dn)) : (rsh_nxt >> (LEN_17 - dn));
    if (dfem) dd = 17'h00000;
    rlo_nxt = rlo_r;
    rhi_nxt = rhi_r;
    rx9_nxt = rx9_r;
    fe_nxt  = fe_r;
    upe_nxt = upe_r;
    fem_nxt = fem_r;
    f17_nxt = f17_r;
    s1_nxt  = s1_r;
    s2_nxt  = s2_r;
    rxc_nxt = rxc_r & ~rd_low;
    dor_nxt = dor_r & ~rd_low;
    if (done || dfem) begin
      if (rxc_r && !rd_low) begin
        dor_nxt = 1'b1;
      end else begin
        rxc_nxt = 1'b1;
        rlo_nxt = dd[7:0];
        rhi_nxt = ext_r ? dd[15:8] : 8'h00;
        rx9_nxt = ext_r ? dd[16] : dd[8];
        fe_nxt  = rfe_nxt & ~manch_r & ~dfem;
        upe_nxt = rupe_nxt & ~manch_r & ~dfem;
        fem_nxt = dfem;
        f17_nxt = rf17_nxt & done;
        if (manch_r) begin
          s1_nxt = rs1_nxt;
          s2_nxt = b;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_r      <= R_IDLE;
      rph_r     <= 1'b0;
      rha_r     <= 1'b0;
      rcnt_r    <= 5'h00;
      rsh_r     <= 17'h00000;
      rpar_r    <= 1'b0;
      rfe_r     <= 1'b0;
      rupe_r    <= 1'b0;
      rs1_r     <= 1'b0;
      rf17_r    <= 1'b0;
      rlo_r     <= 8'h00;
      rhi_r     <= 8'h00;
      rx9_r     <= 1'b0;
      rxc_r     <= 1'b0;
      fe_r      <= 1'b0;
      dor_r     <= 1'b0;
      upe_r     <= 1'b0;
      fem_r     <= 1'b0;
      f17_r     <= 1'b0;
      s1_r      <= 1'b0;
      s2_r      <= 1'b0;
      rxd_owned <= 1'b0;
    end else begin
      rs_r      <= rs_nxt;
      rph_r     <= rph_nxt;
      rha_r     <= rha_nxt;
      rcnt_r    <= rcnt_nxt;
      rsh_r     <= rsh_nxt;
      rpar_r    <= rpar_nxt;
      rfe_r     <= rfe_nxt;
      rupe_r    <= rupe_nxt;
      rs1_r     <= rs1_nxt;
      rf17_r    <= rf17_nxt;
      rlo_r     <= rlo_nxt;
      rhi_r     <= rhi_nxt;
      rx9_r     <= rx9_nxt;
      rxc_r     <= rxc_nxt;
      fe_r      <= fe_nxt;
      dor_r     <= dor_nxt;
      upe_r     <= upe_nxt;
      fem_r     <= fem_nxt;
      f17_r     <= f17_nxt;
      s1_r      <= s1_nxt;
      s2_r      <= s2_nxt;
      rxd_owned <= rx_en_nxt;
    end
  end

endmodule

// ==== tb/eup_core_properties.sv ====
// Checker for the serial data path, watching only its ports.
// Assumes one clock domain and the byte offsets of the package.
module eup_core_properties
  import eup_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd_pin,
  input wire logic        xck_pin,
  input wire logic        txd_pin,
  input wire logic        txd_pin_oe,
  input wire logic        rxd_owned
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_LINE_CFG);
  wire rd_done = pready && !pwrite;
  ////////////////////////////////////////////////////////////////////////
  AST_PREADY_WAIT: assert property (acc && !pready |-> ##[1:2] pready)
    else $error("access not answered in time");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_PREADY_IN_ACCESS: assert property (pready |-> acc)
    else $error("ready outside access phase");
  AST_SLVERR_MAP: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match address map");
  AST_SLVERR_RDATA: assert property (rd_done && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_SIZE_WIDTH: assert property (rd_done && paddr == OFS_SIZE_CFG |-> prdata[31:8] == 24'h0)
    else $error("size register wider than eight bits");
  AST_HIGH_WIDTH: assert property (rd_done && paddr == OFS_DATA_HIGH |-> prdata[31:8] == 24'h0)
    else $error("high data wider than eight bits");
  AST_RX_OWN: assert property (pready && pwrite && paddr == OFS_CTRL_B
    |=> rxd_owned == $past(pwdata[CB_RX_EN]))
    else $error("receive pin ownership does not follow enable");
  AST_TX_IDLE: assert property (!txd_pin_oe |-> txd_pin)
    else $error("line not idle while transmitter released");
  AST_OE_DROP_IDLE: assert property ($fell(txd_pin_oe) |-> $past(txd_pin) && $past(txd_pin, 2))
    else $error("transmitter released in mid frame");
  AST_TX_START_OWNED: assert property ($fell(txd_pin) |-> txd_pin_oe)
    else $error("start bit without transmitter owning pin");
  ////////////////////////////////////////////////////////////////////////
  COV_REFUSED: cover property (pready && pslverr);
  COV_DRAIN: cover property ($fell(txd_pin_oe));
  COV_LOW_READ: cover property (rd_done && paddr == OFS_DATA_LOW);
  COV_MANCH_FEM: cover property (rd_done && paddr == OFS_EXT_STAT && prdata[ES_FEM]);
endmodule

// ==== tb/eup_peer.sv ====
// Remote serial peer: level or Manchester frames, LSB first, one clock.
// Assumes the line idles high through a pull-up between frames.
module eup_peer #(
  parameter int DIV = 8
) (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int          rlen = 8;
  logic [16:0] rq [$];
  logic [16:0] sh;
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // Receive frames from the block, sampled at mid bit
  always begin
    @(negedge txd);
    repeat (DIV / 2) @(posedge pclk);
    if (txd == 1'b0) begin
      sh = 17'h0;
      for (int i = 0; i < rlen; i++) begin
        repeat (DIV) @(posedge pclk);
        sh[i] = txd;
      end
      repeat (DIV) @(posedge pclk);
      rq.push_back(sh);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Send start, n bits, stop of given level, then idle
  task automatic send(input logic [17:0] b, input int n, input logic stopv);
    @(posedge pclk) rxd <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (DIV) @(posedge pclk);
      rxd <= b[i];
    end
    repeat (DIV) @(posedge pclk);
    rxd <= stopv;
    repeat (DIV) @(posedge pclk);
    rxd <= 1'b1;
    repeat (DIV) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Manchester frame; bit number bad gets no mid-bit transition
  task automatic msend(input logic [16:0] b, input int n, input int bad);
    @(posedge pclk) rxd <= 1'b0;
    repeat (DIV / 2) @(posedge pclk);
    rxd <= 1'b1;
    for (int i = 0; i < n; i++) begin
      repeat (DIV / 2) @(posedge pclk);
      rxd <= (i == bad) ? b[i] : ~b[i];
      repeat (DIV / 2) @(posedge pclk);
      rxd <= b[i];
    end
    repeat (DIV / 2) @(posedge pclk);
    rxd <= 1'b1;
    repeat (3 * DIV) @(posedge pclk);
  endtask
endmodule

// ==== tb/eup_core_bench.sv ====
// Self-checking bench for the serial data path.
// Assumes the peer model and the checker bound below.
module eup_core_bench
  import eup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] code; logic [4:0] len;} eup_row_s;
  localparam logic [16:0] PAT = 17'h1A5C3;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        txd_pin, txd_pin_oe, rxd_owned, rxd, err, external_serial_clock;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [16:0] x;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          k;
  eup_row_s    rows [10] = '{'{4'h0, 5'h05}, '{4'h1, 5'h06}, '{4'h2, 5'h07},
    '{4'h3, 5'h08}, '{4'h7, 5'h09}, '{4'h8, 5'h0D}, '{4'h9, 5'h0E},
    '{4'hA, 5'h0F}, '{4'hB, 5'h10}, '{4'hF, 5'h11}};
  eup_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_pin(rxd), .xck_pin(external_serial_clock), .txd_pin(txd_pin),
    .txd_pin_oe(txd_pin_oe), .rxd_owned(rxd_owned));
  eup_peer #(.DIV(8)) peer (.pclk(pclk), .txd(txd_pin), .rxd(rxd));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    external_serial_clock <= cyc[2];
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      summarize;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, r);
  endtask
  task automatic pop(input logic [31:0] e, input string nm);
    logic [31:0] g = 'x;
    int j = 0;
    while (peer.rq.size() == 0 && j < 3000) begin
      @(posedge pclk);
      j++;
    end
    if (peer.rq.size() > 0) g = {15'h0, peer.rq.pop_front()};
    chk(nm, e, g);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_SIZE_CFG, 32'h33, "size reset");
    rd(OFS_STAT_A, 32'h20, "status reset");
    chk("rx own off", 32'h0, {31'h0, rxd_owned});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("test reset done");
    wr(OFS_LINE_CFG, 32'h8);
    wr(OFS_EXT_CTRL, 32'h10);
    foreach (rows[i]) begin
      x = PAT & ~(17'h1FFFF << rows[i].len);
      peer.rlen = int'(rows[i].len);
      wr(OFS_SIZE_CFG, {24'h0, rows[i].code, rows[i].code});
      wr(OFS_CTRL_B, 32'h19);
      wr(OFS_DATA_HIGH, {24'h0, PAT[15:8]});
      wr(OFS_DATA_LOW, {24'h0, PAT[7:0]});
      pop({15'h0, x}, "tx char");
      peer.send({1'b0, x}, int'(rows[i].len), 1'b1);
      rd(OFS_STAT_A, 32'hA0, "rx done");
      rd(OFS_CTRL_B, rows[i].len == 5'h11 ? 32'h1B : 32'h19, "rx ninth");
      rd(OFS_DATA_HIGH, {24'h0, x[15:8]}, "rx high");
      rd(OFS_DATA_LOW, {24'h0, x[7:0]}, "rx low");
      rd(OFS_STAT_A, 32'h20, "rx cleared");
    end
    chk("rx own on", 32'h1, {31'h0, rxd_owned});
    $display("test sizes done");
    wr(OFS_SIZE_CFG, 32'h33);
    peer.rlen = 8;
    wr(OFS_EXT_CTRL, 32'h11);
    wr(OFS_DATA_LOW, 32'h01);
    pop(32'h80, "msb tx");
    peer.send(18'h080, 8, 1'b1);
    rd(OFS_DATA_LOW, 32'h01, "msb rx");
    wr(OFS_EXT_CTRL, 32'h10);
    $display("test order done");
    wr(OFS_LINE_CFG, 32'h20008);
    peer.send(18'h103, 9, 1'b1);
    rd(OFS_STAT_A, 32'hA4, "parity err");
    rd(OFS_DATA_LOW, 32'h03, "parity char");
    peer.send(18'h003, 9, 1'b0);
    rd(OFS_STAT_A, 32'hB0, "frame err");
    rd(OFS_DATA_LOW, 32'h03, "frame char");
    peer.send(18'h011, 9, 1'b1);
    peer.send(18'h022, 9, 1'b1);
    rd(OFS_STAT_A, 32'hA8, "overrun");
    rd(OFS_DATA_LOW, 32'h11, "kept char");
    rd(OFS_STAT_A, 32'h20, "flags cleared");
    wr(OFS_LINE_CFG, 32'h40008);
    peer.send(18'h05A, 8, 1'b1);
    rd(OFS_DATA_LOW, 32'h5A, "sync rx");
    wr(OFS_LINE_CFG, 32'h8);
    $display("test errors done");
    wr(OFS_EXT_CTRL, 32'h12);
    peer.msend(17'h0A5, 8, 99);
    rd(OFS_EXT_STAT, 32'h03, "manch status");
    rd(OFS_STAT_A, 32'hA0, "manch done");
    rd(OFS_DATA_LOW, 32'hA5, "manch char");
    peer.msend(17'h080, 8, 7);
    rd(OFS_STAT_A, 32'hA0, "manch fe");
    apb(1'b0, OFS_EXT_STAT, 32'h0);
    chk("fem flag", 32'h8, r & 32'h8);
    rd(OFS_DATA_LOW, 32'h00, "fem char");
    wr(OFS_SIZE_CFG, 32'h3E);
    peer.msend(17'h1A5C3, 17, 99);
    rd(OFS_EXT_STAT, 32'h07, "auto 17");
    rd(OFS_DATA_HIGH, 32'hA5, "auto high");
    rd(OFS_DATA_LOW, 32'hC3, "auto low");
    wr(OFS_SIZE_CFG, 32'h33);
    wr(OFS_EXT_CTRL, 32'h10);
    $display("test manchester done");
    wr(OFS_DATA_LOW, 32'h55);
    wr(OFS_CTRL_B, 32'h10);
    chk("oe draining", 32'h1, {31'h0, txd_pin_oe});
    pop(32'h55, "drain char");
    k = 0;
    while (txd_pin_oe === 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    chk("oe released", 32'h0, {31'h0, txd_pin_oe});
    $display("test disable done");
    summarize;
  end
endmodule

bind eup_core eup_core_properties u_prop (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd_pin(rxd_pin), .xck_pin(xck_pin),
  .txd_pin(txd_pin), .txd_pin_oe(txd_pin_oe), .rxd_owned(rxd_owned));
